// ===== bemf_recirc_ctrl.sv
// Bridge recirculation select, zero-crossing detect and current limit
// Assumes synchronous inputs and an outside commutation sequencer
`timescale 1ns/10ps
`default_nettype none
`include "bemf_cfg.svh"

module bemf_recirc_ctrl (
   input wire logic mclk,
   input wire logic rst,
   input wire bemf_pkg::bus_req_t bus,
   output logic [15:0] rd_data,
   input wire logic phase_a_sense,
   input wire logic phase_b_sense,
   input wire logic phase_c_sense,
   input wire logic [2:0] comm_step,
   input wire logic comm_start,
   input wire logic ext_pwm,
   input wire logic duty_on,
   input wire logic cur_over,
   output var bemf_pkg::gate_t gate,
   output logic zc_event
);
   import bemf_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   logic [15:0] ctrl_reg;
   logic [1:0] recirc_select;
   logic degauss_comp_en;
   logic [1:0] ctrl_mode;
   logic [4:0] off_time_setting;
   step_map_t map;
   logic sel_cmp;
   logic target;
   logic zc_filt;
   logic zc_match;
   zc_state_t zc_state;
   logic bridge_req;
   logic limit_busy;
   logic off_start;
   logic drive;
   path_t rc_path;
   path_t path_next;
   path_t path_reg;
   logic [2:0] hi_next;
   logic [2:0] lo_next;
   logic [15:0] status;
   logic [11:0] exp_len;
   logic [11:0] busy_cnt;

   // ****************************************
   // Register port
   // ****************************************

   // Control register write
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (bus.wr && bus.addr == `ADDR_CTRL) begin
         ctrl_reg <= {6'h00, bus.wdata[9:0]};
      end
   end

   // Control fields
   assign recirc_select = ctrl_reg[`CTRL_RECIRC_LSB +: 2];
   assign degauss_comp_en = ctrl_reg[`CTRL_DGC_BIT];
   assign ctrl_mode = ctrl_reg[`CTRL_MODE_LSB +: 2];
   assign off_time_setting = ctrl_reg[`CTRL_OFFT_LSB +: 5];

   // Live state for software
   assign status = {4'h0, comm_step, limit_busy, zc_filt, zc_state, path_reg};

   // Read data in the cycle after the strobe only
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_data <= 16'h0000;
      end else if (bus.rd && bus.addr == `ADDR_CTRL) begin
         rd_data <= ctrl_reg;
      end else if (bus.rd && bus.addr == `ADDR_STATUS) begin
         rd_data <= status;
      end else begin
         rd_data <= 16'h0000;
      end
   end

   // ****************************************
   // Commutation step decode
   // ****************************************

   // Source, sink and floating phase per step
   function automatic step_map_t step_decode(input logic [2:0] step);
      step_map_t m;
      m = '{hi: 2'h3, lo: 2'h3, und: 2'h3, rising: 1'b0};
      case (step)
         3'h0: m = '{hi: 2'h0, lo: 2'h1, und: 2'h2, rising: 1'b1};
         3'h1: m = '{hi: 2'h0, lo: 2'h2, und: 2'h1, rising: 1'b0};
         3'h2: m = '{hi: 2'h1, lo: 2'h2, und: 2'h0, rising: 1'b1};
         3'h3: m = '{hi: 2'h1, lo: 2'h0, und: 2'h2, rising: 1'b0};
         3'h4: m = '{hi: 2'h2, lo: 2'h0, und: 2'h1, rising: 1'b1};
         3'h5: m = '{hi: 2'h2, lo: 2'h1, und: 2'h0, rising: 1'b0};
         default: m = '{hi: 2'h3, lo: 2'h3, und: 2'h3, rising: 1'b0};
      endcase
      return m;
   endfunction

   assign map = step_decode(comm_step);
   assign target = map.rising;

   // Comparator of the floating phase against the centre tap
   always_comb begin
      case (map.und)
         2'h0: sel_cmp = phase_a_sense;
         2'h1: sel_cmp = phase_b_sense;
         2'h2: sel_cmp = phase_c_sense;
         default: sel_cmp = 1'b0;
      endcase
   end

   // ****************************************
   // Zero-crossing detection
   // ****************************************

   // Filter seeded at commutation: past-crossing level under degauss
   zc_filter #(
      .DEPTH(`ZC_FILTER_CYCLES)
   ) u_filter (
      .mclk(mclk),
      .rst(rst),
      .raw(sel_cmp),
      .seed_load(comm_start),
      .seed_val(degauss_comp_en ? target : !target),
      .filt(zc_filt)
   );

   // Crossing seen on the filtered level only
   assign zc_match = (zc_state == ZC_ARMED) && !comm_start && (zc_filt == target);

   // Crossing state per commutation period
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         zc_state <= ZC_DONE;
      end else if (comm_start) begin
         zc_state <= degauss_comp_en ? ZC_WAIT : ZC_ARMED;
      end else begin
         case (zc_state)
            ZC_WAIT: begin
               if (zc_filt == !target) begin
                  zc_state <= ZC_ARMED;
               end
            end
            ZC_ARMED: begin
               if (zc_match) begin
                  zc_state <= ZC_DONE;
               end
            end
            ZC_DONE: begin
               zc_state <= ZC_DONE;
            end
            default: begin
               zc_state <= ZC_DONE;
            end
         endcase
      end
   end

   // Crossing pulse to the sequencer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         zc_event <= 1'b0;
      end else begin
         zc_event <= zc_match;
      end
   end

   // ****************************************
   // Bridge PWM and current limit
   // ****************************************

   // On request by control mode
   always_comb begin
      case (ctrl_mode)
         `MODE_DIRECT: bridge_req = ext_pwm;
         `MODE_INDIRECT: bridge_req = duty_on;
         `MODE_SPEED: bridge_req = duty_on;
         default: bridge_req = 1'b1;
      endcase
   end

   // Over-current trips one off time in every mode
   assign off_start = cur_over && bridge_req && !limit_busy;
   assign drive = bridge_req && !limit_busy && !cur_over;

   // Off time equals programmed period in every mode
   offtime_timer #(
      .TICK_CYCLES(`TICK_CYCLES)
   ) u_offtime (
      .mclk(mclk),
      .rst(rst),
      .start(off_start),
      .setting(off_time_setting),
      .busy(limit_busy)
   );

   // ****************************************
   // Recirculation path
   // ****************************************

   // Path for the off interval
   always_comb begin
      case (recirc_select)
         `RECIRC_LOW: rc_path = PATH_LOW;
         `RECIRC_HIGH: rc_path = PATH_HIGH;
         `RECIRC_FAST: rc_path = PATH_FAST;
         default: begin
            if (target ^ (zc_state == ZC_DONE)) begin
               rc_path = PATH_HIGH;
            end else begin
               rc_path = PATH_LOW;
            end
         end
      endcase
   end

   assign path_next = drive ? PATH_DRIVE : rc_path;

   // Current path register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         path_reg <= PATH_FAST;
      end else begin
         path_reg <= path_next;
      end
   end

   // Gate pattern per phase
   for (genvar p = 0; p < 3; p++) begin : g_phase
      assign hi_next[p] = (path_next == PATH_DRIVE && map.hi == 2'(p))
         || (path_next == PATH_HIGH && (map.hi == 2'(p) || map.lo == 2'(p)));
      assign lo_next[p] = (path_next == PATH_DRIVE && map.lo == 2'(p))
         || (path_next == PATH_LOW && (map.hi == 2'(p) || map.lo == 2'(p)));
   end

   // Gate outputs, all off in reset
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         gate <= '0;
      end else begin
         gate.hi <= hi_next;
         gate.lo <= lo_next;
      end
   end

   // ****************************************
   // Checks
   // ****************************************

   // Expected and measured off-time length
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         exp_len <= 12'h000;
         busy_cnt <= 12'h000;
      end else if (off_start) begin
         exp_len <= (12'(`OFF_BASE_TICKS) + 12'(`OFF_STEP_TICKS)
            * {7'h00, off_time_setting}) * 12'(`TICK_CYCLES);
         busy_cnt <= 12'h000;
      end else if (limit_busy) begin
         busy_cnt <= busy_cnt + 12'h001;
      end
   end

   a_low_path: assert property (@(posedge mclk) disable iff (rst)
      (recirc_select == `RECIRC_LOW && !drive)
      |=> (path_reg == PATH_LOW) && (gate.hi == 3'h0))
      else $error("low-side recirculation not selected");

   a_high_path: assert property (@(posedge mclk) disable iff (rst)
      (recirc_select == `RECIRC_HIGH && !drive)
      |=> (path_reg == PATH_HIGH) && (gate.lo == 3'h0))
      else $error("high-side recirculation not selected");

   a_fast_off: assert property (@(posedge mclk) disable iff (rst)
      (path_reg == PATH_FAST) |-> (gate.hi == 3'h0) && (gate.lo == 3'h0))
      else $error("switch on during fast decay");

   a_mixed_fall: assert property (@(posedge mclk) disable iff (rst)
      (recirc_select == `RECIRC_MIXED && !drive && map.und != 2'h3
      && !map.rising && zc_state != ZC_DONE) |=> (path_reg == PATH_LOW))
      else $error("mixed mode falling phase not low-side");

   a_mixed_rise: assert property (@(posedge mclk) disable iff (rst)
      (recirc_select == `RECIRC_MIXED && !drive && map.rising
      && zc_state == ZC_DONE) |=> (path_reg == PATH_LOW))
      else $error("mixed mode rising phase not low-side after crossing");

   a_mixed_rise_pre: assert property (@(posedge mclk) disable iff (rst)
      (recirc_select == `RECIRC_MIXED && !drive && map.rising
      && zc_state != ZC_DONE) |=> (path_reg == PATH_HIGH))
      else $error("mixed mode rising phase not high-side before crossing");

   a_mixed_fall_post: assert property (@(posedge mclk) disable iff (rst)
      (recirc_select == `RECIRC_MIXED && !drive && map.und != 2'h3
      && !map.rising && zc_state == ZC_DONE) |=> (path_reg == PATH_HIGH))
      else $error("mixed mode falling phase not high-side after crossing");

   a_zc_filtered: assert property (@(posedge mclk) disable iff (rst)
      $rose(zc_event) |-> $past(zc_state) == ZC_ARMED
      && $past(zc_filt) == $past(target))
      else $error("crossing reported without filtered polarity");

   a_degauss_hold: assert property (@(posedge mclk) disable iff (rst)
      (zc_state == ZC_WAIT) |=> !zc_event)
      else $error("crossing reported while phase clamped");

   a_off_length: assert property (@(posedge mclk) disable iff (rst)
      $fell(limit_busy) |-> (busy_cnt == exp_len))
      else $error("off time length wrong");

   a_limit_recirc: assert property (@(posedge mclk) disable iff (rst)
      off_start |=> limit_busy && (path_reg != PATH_DRIVE))
      else $error("bridge still driving after over-current");

   a_reset_mixed: assert property (@(posedge mclk)
      rst |=> (recirc_select == `RECIRC_MIXED))
      else $error("recirculation select not mixed after reset");
endmodule
`default_nettype wire

// ===== bemf_cfg.svh
// Constants for the recirculation and current-limit controller
// Assumes a 25 MHz system clock; included by bare name
`ifndef BEMF_CFG_SVH
`define BEMF_CFG_SVH

// ****************************************
// Register map
// ****************************************
`define ADDR_CTRL 4'h0
`define ADDR_STATUS 4'h1
`define CTRL_RESET 16'h0000
`define CTRL_RECIRC_LSB 0
`define CTRL_DGC_BIT 2
`define CTRL_MODE_LSB 3
`define CTRL_OFFT_LSB 5

// ****************************************
// Field codes
// ****************************************
`define RECIRC_MIXED 2'b00
`define RECIRC_HIGH 2'b01
`define RECIRC_LOW 2'b10
`define RECIRC_FAST 2'b11
`define MODE_DIRECT 2'b00
`define MODE_INDIRECT 2'b01
`define MODE_SPEED 2'b10
`define MODE_CURRENT 2'b11

// ****************************************
// Timing
// ****************************************
`define CLK_PERIOD_NS 40
`define OFF_BASE_NS 20000
`define OFF_STEP_NS 1600
`define TICK_NS 400
`define TICK_CYCLES (`TICK_NS / `CLK_PERIOD_NS)
`define OFF_BASE_TICKS (`OFF_BASE_NS / `TICK_NS)
`define OFF_STEP_TICKS (`OFF_STEP_NS / `TICK_NS)
`define ZC_FILTER_CYCLES 8

`endif

// ===== bemf_pkg.sv
// Types shared by the recirculation controller and its tests
// Assumes nothing beyond a SystemVerilog compiler
package bemf_pkg;
   typedef enum logic [3:0] {
      PATH_DRIVE = 4'b0001,
      PATH_LOW = 4'b0010,
      PATH_HIGH = 4'b0100,
      PATH_FAST = 4'b1000
   } path_t;
   typedef enum logic [2:0] {
      ZC_WAIT = 3'b001,
      ZC_ARMED = 3'b010,
      ZC_DONE = 3'b100
   } zc_state_t;
   typedef struct packed {
      logic [2:0] hi;
      logic [2:0] lo;
   } gate_t;
   typedef struct packed {
      logic [1:0] hi;
      logic [1:0] lo;
      logic [1:0] und;
      logic rising;
   } step_map_t;
   typedef struct packed {
      logic [3:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } bus_req_t;
endpackage

// ===== zc_filter.sv
// Stability filter for the zero-crossing comparator
// Assumes raw is synchronous to mclk
`timescale 1ns/10ps
`default_nettype none
`include "bemf_cfg.svh"
module zc_filter #(
   parameter int DEPTH = `ZC_FILTER_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic raw,
   input wire logic seed_load,
   input wire logic seed_val,
   output logic filt
);
   logic [7:0] run_cnt;

   // Flip only after DEPTH cycles of disagreement
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         filt <= 1'b0;
         run_cnt <= 8'h00;
      end else if (seed_load) begin
         filt <= seed_val;
         run_cnt <= 8'h00;
      end else if (raw == filt) begin
         run_cnt <= 8'h00;
      end else if (run_cnt == 8'(DEPTH - 1)) begin
         filt <= raw;
         run_cnt <= 8'h00;
      end else begin
         run_cnt <= run_cnt + 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== offtime_timer.sv
// Fixed off-time timer, counted in divided clock ticks
// Assumes start is a one-cycle pulse
`timescale 1ns/10ps
`default_nettype none
`include "bemf_cfg.svh"
module offtime_timer #(
   parameter int TICK_CYCLES = `TICK_CYCLES
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic start,
   input wire logic [4:0] setting,
   output logic busy
);
   logic [3:0] tick_cnt;
   logic [7:0] ticks_left;
   logic [7:0] load;

   // Base ticks plus step ticks per setting unit
   assign load = 8'(`OFF_BASE_TICKS) + 8'(`OFF_STEP_TICKS) * {3'b000, setting};
   assign busy = (ticks_left != 8'h00);

   // Tick divider and remaining tick count
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tick_cnt <= 4'h0;
         ticks_left <= 8'h00;
      end else if (start) begin
         tick_cnt <= 4'h0;
         ticks_left <= load;
      end else if (busy) begin
         if (tick_cnt == 4'(TICK_CYCLES - 1)) begin
            tick_cnt <= 4'h0;
            ticks_left <= ticks_left - 8'h01;
         end else begin
            tick_cnt <= tick_cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== bridge_model.sv
// Behavioural bridge and motor as seen through the phase comparators
// Assumes gate is the registered switch word of the controller
`timescale 1ns/10ps
`default_nettype none
module bridge_model (
   input wire bemf_pkg::gate_t gate,
   input wire logic bemf,
   output logic phase_a_sense,
   output logic phase_b_sense,
   output logic phase_c_sense,
   output logic shoot_thru
);
   import bemf_pkg::*;
   logic [2:0] ph;
   // ***************
   // Phase levels
   // ***************
   // Switched phases follow their switch, an open phase shows back-EMF
   always_comb begin
      for (int i = 0; i < 3; i++) begin
         ph[i] = gate.hi[i] ? 1'b1 : (gate.lo[i] ? 1'b0 : bemf);
      end
   end
   assign phase_a_sense = ph[0];
   assign phase_b_sense = ph[1];
   assign phase_c_sense = ph[2];
   // Both switches of one leg on at once
   assign shoot_thru = |(gate.hi & gate.lo);
endmodule
`default_nettype wire

// ===== bemf_recirc_ctrl_tb.sv
// Self-checking bench for the recirculation and current-limit controller
// Assumes the package, the design files and bridge_model are compiled first
`timescale 1ns/10ps
`default_nettype none
module bemf_recirc_ctrl_tb;
   import bemf_pkg::*;
   localparam int HI_IDX [6] = '{0, 0, 1, 1, 2, 2};
   localparam int LO_IDX [6] = '{1, 2, 2, 0, 0, 1};
   logic mclk, rst, comm_start, ext_pwm, duty_on, cur_over, bemf, zc_event;
   logic pa, pb, pc, fault, rd_d;
   logic [2:0] comm_step;
   logic [15:0] rd_data;
   bus_req_t bus;
   gate_t gate;
   logic [15:0] rd_q[$];
   logic [2:0] zc_q[$];
   int miscompares, n_checks, cyc;
   bemf_recirc_ctrl i_dut (.mclk(mclk), .rst(rst), .bus(bus), .rd_data(rd_data),
      .phase_a_sense(pa), .phase_b_sense(pb), .phase_c_sense(pc), .comm_step(comm_step),
      .comm_start(comm_start), .ext_pwm(ext_pwm), .duty_on(duty_on), .cur_over(cur_over),
      .gate(gate), .zc_event(zc_event));
   bridge_model i_bridge (.gate(gate), .bemf(bemf), .phase_a_sense(pa),
      .phase_b_sense(pb), .phase_c_sense(pc), .shoot_thru(fault));
   // ***************
   // Helpers
   // ***************
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic tick(input int k);
      repeat (k) @(posedge mclk);
   endtask
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t word %h expected %h", $time, got, exp);
      end
   endtask
   task automatic check_gate(input gate_t got, input gate_t exp);
      n_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t gates %b expected %b", $time, got, exp);
      end
   endtask
   task automatic results();
      if (miscompares == 0 && n_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Expected switch word: 0 drive, 1 high, 2 low, 3 all off
   function automatic gate_t pg(input int s, input int p);
      gate_t g;
      logic [2:0] hm, lm;
      hm = 3'h1 << HI_IDX[s];
      lm = 3'h1 << LO_IDX[s];
      g = '0;
      if (p == 0) begin
         g.hi = hm;
         g.lo = lm;
      end else if (p == 1) begin
         g.hi = hm | lm;
      end else if (p == 2) begin
         g.lo = hm | lm;
      end
      return g;
   endfunction
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      bus.addr <= a;
      bus.wdata <= d;
      bus.wr <= 1'b1;
      tick(1);
      bus.wr <= 1'b0;
      tick(1);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] exp);
      rd_q.push_back(exp);
      bus.addr <= a;
      bus.rd <= 1'b1;
      tick(1);
      bus.rd <= 1'b0;
      tick(1);
   endtask
   // Trip the limit, held past the start, and measure the off time
   task automatic trip(input int s, input int p, input int len);
      int c;
      check_gate(gate, pg(s, 0));
      cur_over <= 1'b1;
      tick(3);
      cur_over <= 1'b0;
      #1;
      check_gate(gate, pg(s, p));
      c = 3;
      while (gate === pg(s, p) && c < 3000) begin
         @(posedge mclk);
         #1;
         c++;
      end
      check_gate(gate, pg(s, 0));
      // Gates are registered, so recirculation stands one cycle past the off time
      check_word(16'(c - 1), 16'(len + 1));
      tick(1);
   endtask
   // ***************
   // Result monitor
   // ***************
   always @(posedge mclk) begin
      rd_d <= bus.rd;
      cyc++;
      if (rd_d === 1'b1) begin
         check_word(rd_data, rd_q.pop_front());
      end
      if (zc_event === 1'b1) begin
         if (zc_q.size() == 0) begin
            check_word(16'h1, 16'h0);
         end else begin
            check_word({13'h0, comm_step}, {13'h0, zc_q.pop_front()});
         end
      end
      if (fault === 1'b1) begin
         check_word(16'h1, 16'h0);
      end
      if (cyc == 40000) begin
         miscompares++;
         results();
      end
   end
   // ***************
   // Main sequence
   // ***************
   initial begin
      int s, m, r, set;
      logic rise;
      rst = 1'b1;
      bus = '0;
      comm_step = 3'h0;
      comm_start = 1'b0;
      ext_pwm = 1'b1;
      duty_on = 1'b1;
      cur_over = 1'b0;
      bemf = 1'b0;
      void'($urandom(32'h62df));
      tick(16);
      rst <= 1'b0;
      tick(1);
      rd(4'h0, 16'h0000);
      wr(4'h0, 16'hffff);
      rd(4'h0, 16'h03ff);
      wr(4'h7, 16'h1234);
      rd(4'h7, 16'h0000);
      rd(4'h0, 16'h03ff);
      // Fixed recirculation paths in every control mode
      for (m = 0; m < 4; m++) begin
         for (r = 1; r < 4; r++) begin
            set = $urandom % 32;
            wr(4'h0, {6'h0, set[4:0], m[1:0], 1'b0, r[1:0]});
            tick(3);
            if (m != 3) begin
               if (m == 0) begin
                  ext_pwm <= 1'b0;
               end else begin
                  duty_on <= 1'b0;
               end
               tick(3);
               check_gate(gate, pg(0, r));
               ext_pwm <= 1'b1;
               duty_on <= 1'b1;
               tick(3);
            end
            trip(0, r, 500 + 40 * set);
         end
      end
      // Mixed mode around a filtered crossing in each step
      wr(4'h0, 16'h0018);
      for (s = 0; s < 6; s++) begin
         rise = (s % 2 == 0);
         comm_step <= s[2:0];
         bemf <= !rise;
         comm_start <= 1'b1;
         tick(1);
         comm_start <= 1'b0;
         tick(3);
         trip(s, rise ? 1 : 2, 500);
         bemf <= rise;
         tick(7);
         bemf <= !rise;
         tick(10);
         zc_q.push_back(s[2:0]);
         bemf <= rise;
         tick(7);
         check_word(16'(zc_q.size()), 16'h1);
         tick(6);
         check_word(16'(zc_q.size()), 16'h0);
         trip(s, rise ? 2 : 1, 500);
      end
      // Degauss: clamp level ignored until it releases
      wr(4'h0, 16'h001c);
      comm_step <= 3'h0;
      bemf <= 1'b1;
      comm_start <= 1'b1;
      tick(1);
      comm_start <= 1'b0;
      tick(20);
      bemf <= 1'b0;
      tick(12);
      zc_q.push_back(3'h0);
      bemf <= 1'b1;
      tick(14);
      check_word(16'(zc_q.size()), 16'h0);
      rd(4'h1, 16'h00c1);
      comm_step <= 3'h6;
      tick(3);
      check_gate(gate, gate_t'(6'h0));
      check_word(16'(rd_q.size()), 16'h0);
      results();
   end
endmodule
`default_nettype wire
